// >>> logic/gpab_map.vh
// register map, field positions and reset values of the port A/B gpio block
// assumes a 32-bit apb bus; offsets below are register indexes, byte address is four times one
`ifndef GPAB_MAP_VH
`define GPAB_MAP_VH
`define GPAB_PA_PULLUP_OFS 24'hFF0019
`define GPAB_PA_DATA_OFS 24'hFFFFE9
`define GPAB_PB_DIR_OFS 24'hFFFFFA
`define GPAB_PA_DIR_OFS 24'hFFFFF9
`define GPAB_MODE_SEL_OFS 24'hFF0009
`define GPAB_MODE_PIN4_BIT 3
`define GPAB_MODE_PB0_BIT 2
`define GPAB_MODE_MASK 8'h0C
`define GPAB_REG_RST 8'h00
`define GPAB_SYNC_RST 8'h00
`endif

// >>> logic/gpab_sync.v
// two-flop synchroniser for an 8-bit group of pin levels
// assumes pins change slowly; bits may resolve in different cycles
`timescale 1ns/100ps
`include "gpab_map.vh"
module gpab_sync (
	input wire clk_i, // system clock
	input wire rst_n_i, // sync reset, active low
	input wire [7:0] d_i, // asynchronous pin levels
	output reg [7:0] q_o // synchronised levels
);
	reg [7:0] meta_ff;
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			meta_ff <= `GPAB_SYNC_RST;
			q_o <= `GPAB_SYNC_RST;
		end
		else
		begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule

// >>> logic/gpab_regs.v
// apb register slave of the port A/B gpio block
// assumes word-aligned apb; byte address is four times the register index, data in bits 7:0
`timescale 1ns/100ps
`include "gpab_map.vh"
module gpab_regs (
	input wire clk_i, // system clock
	input wire rst_n_i, // sync reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [31:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	input wire [7:0] pa_rdata_i, // port A data readback value
	output reg [31:0] prdata, // apb read data
	output reg pslverr, // unmapped address
	output reg [7:0] pa_data_o, // port A output data
	output reg [7:0] pa_dir_o, // port A direction
	output reg [7:0] pa_pu_o, // port A pull-up enables
	output reg [7:0] pb_dir_o, // port B direction
	output reg [7:0] mode_o // analog select bits
);
	wire acc;
	wire [31:0] a;
	reg [7:0] rd;
	reg hit;
	assign acc = psel & penable;
	assign a = paddr;
	// one register per word: index in bits 25:2, lane bits ignored
	function is_reg;
		input [31:0] ad;
		input [23:0] ofs;
		begin
			is_reg = (ad[31:26] == 6'h00) && (ad[25:2] == ofs);
		end
	endfunction
	always @*
	begin
		rd = 8'h00;
		hit = 1'b1;
		if (is_reg(a, `GPAB_PA_DATA_OFS))
			rd = pa_rdata_i;
		else if (is_reg(a, `GPAB_PA_PULLUP_OFS))
			rd = pa_pu_o;
		else if (is_reg(a, `GPAB_PB_DIR_OFS))
			rd = pb_dir_o;
		else if (is_reg(a, `GPAB_PA_DIR_OFS))
			rd = pa_dir_o;
		else if (is_reg(a, `GPAB_MODE_SEL_OFS))
			rd = mode_o & `GPAB_MODE_MASK;
		else
			hit = 1'b0;
	end
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pa_data_o <= `GPAB_REG_RST;
			pa_dir_o <= `GPAB_REG_RST;
			pa_pu_o <= `GPAB_REG_RST;
			pb_dir_o <= `GPAB_REG_RST;
			mode_o <= `GPAB_REG_RST;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				prdata <= {24'h000000, rd};
				pslverr <= ~hit;
			end
			if (acc && pwrite && hit)
			begin
				if (is_reg(a, `GPAB_PA_DATA_OFS))
					pa_data_o <= pwdata[7:0];
				if (is_reg(a, `GPAB_PA_PULLUP_OFS))
					pa_pu_o <= pwdata[7:0];
				if (is_reg(a, `GPAB_PB_DIR_OFS))
					pb_dir_o <= pwdata[7:0];
				if (is_reg(a, `GPAB_PA_DIR_OFS))
					pa_dir_o <= pwdata[7:0];
				if (is_reg(a, `GPAB_MODE_SEL_OFS))
					mode_o <= pwdata[7:0] & `GPAB_MODE_MASK;
			end
		end
	end
endmodule

// >>> logic/gpab_top.v
// What this block does
// - port A direction 1 output, 0 input
// - port A output drives stored data bit
// - data read returns stored bit for outputs
// - data read returns pin level for inputs
// - analog-selected port A bits read as 1
// - port A pull-up bit enables pull-up
// - pull-up only on inputs, never analog
// - pin 4 analog only when select set
// - port B pins double as analog
// - port B gpio only when unclaimed
// - port B direction 1 output, 0 input
// - port B pin 0 needs select cleared
//
// top of the port A/B gpio block: apb slave, pin drivers, readback mux
// assumes analog claim inputs come from converter logic on clk_i;
// port B data register lives elsewhere and is fed in on pb_data_i
`timescale 1ns/100ps
`include "gpab_map.vh"
module gpab_top (
	input wire clk_i, // 200 MHz system clock
	input wire rst_n_i, // sync reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [31:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output wire [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error
	input wire [7:0] pa_pin_i, // port A pin levels
	input wire [7:0] pb_pin_i, // port B pin levels, unused inside
	input wire [7:0] pb_data_i, // port B output data from its register
	input wire [7:0] adc1_claim_i, // first converter claims port B pins
	input wire [7:0] adc2_claim_i, // second converter claims port A pins
	input wire [7:0] dac_claim_i, // d/a converter claims port B pins
	input wire [7:0] pfc_input_i, // pin-function controller input pins, port A
	output reg [7:0] pa_out_o, // port A pin output value
	output reg [7:0] pa_oe_o, // port A output enable
	output reg [7:0] pa_pu_o, // port A pull-up enable
	output reg [7:0] pa_analog_o, // port A pin in analog mode
	output reg [7:0] pb_out_o, // port B pin output value
	output reg [7:0] pb_oe_o, // port B output enable
	output reg [7:0] pb_analog_o // port B pin in analog mode
);
	wire [7:0] pa_sync;
	wire [7:0] pa_data;
	wire [7:0] pa_dir;
	wire [7:0] pa_pu;
	wire [7:0] pb_dir;
	wire [7:0] mode;
	reg [7:0] pa_ana;
	reg [7:0] pb_ana;
	reg [7:0] pa_rdata;
	wire [31:0] prdata_w;
	wire pslverr_w;
	gpab_sync u_sync_a (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(pa_pin_i),
		.q_o(pa_sync)
	);
	gpab_regs u_regs (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pa_rdata_i(pa_rdata),
		.prdata(prdata_w),
		.pslverr(pslverr_w),
		.pa_data_o(pa_data),
		.pa_dir_o(pa_dir),
		.pa_pu_o(pa_pu),
		.pb_dir_o(pb_dir),
		.mode_o(mode)
	);
	// zero-wait: answer captured in setup, given with pready high in access
	assign pready = 1'b1;
	// already flops in the slave; a second stage would miss the access cycle
	assign prdata = prdata_w;
	assign pslverr = pslverr_w;
	always @*
	begin
		pa_ana = adc2_claim_i;
		// pin 4 only turns analog with its select bit set
		pa_ana[4] = mode[`GPAB_MODE_PIN4_BIT];
		pb_ana = adc1_claim_i | dac_claim_i;
		// pin 0 analog only with its select bit
		pb_ana[0] = mode[`GPAB_MODE_PB0_BIT];
		// analog 1 beats direction; output gets stored bit; input gets pin
		pa_rdata = pa_ana | (pa_dir & pa_data) | (~pa_dir & pa_sync);
	end
	// pins outputs registered so glitches never reach the pads
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pa_out_o <= `GPAB_REG_RST;
			pa_oe_o <= `GPAB_REG_RST;
			pa_pu_o <= `GPAB_REG_RST;
			pa_analog_o <= `GPAB_REG_RST;
			pb_out_o <= `GPAB_REG_RST;
			pb_oe_o <= `GPAB_REG_RST;
			pb_analog_o <= `GPAB_REG_RST;
		end
		else
		begin
			pa_out_o <= pa_data;
			pa_oe_o <= pa_dir & ~pa_ana;
			// pull-up on gpio or peripheral inputs; never on analog pins
			pa_pu_o <= pa_pu & ~pa_ana & (~pa_dir | pfc_input_i);
			pa_analog_o <= pa_ana;
			pb_out_o <= pb_data_i;
			pb_oe_o <= pb_dir & ~pb_ana;
			pb_analog_o <= pb_ana;
		end
	end
endmodule

// >>> dv/gpab_pins.sv
// port A pin model: device driver, outside driver, pull-up
// assumes same-clock levels from the device
`timescale 1ns/100ps
module gpab_pins (
	input wire [7:0] out_i, // device value
	input wire [7:0] oe_i, // device drives
	input wire [7:0] pu_i, // pull-up on
	input wire [7:0] ext_oe_i, // outside drives
	input wire [7:0] ext_i, // outside value
	output wire [7:0] pin_o // pin level
);
	// a floating pin shows the inverse, never a helpful stale level
	assign pin_o = (oe_i & out_i) | (~oe_i & ((ext_oe_i & ext_i) | (~ext_oe_i & (pu_i | ~ext_i))));
endmodule

// >>> dv/gpab_top_assertions.sv
// port checker of the gpio top
// assumes the bind at the foot
`timescale 1ns/100ps
module gpab_chk (
	input wire clk_i, // clk
	input wire rst_n_i, // rst
	input wire psel, // sel
	input wire penable, // en
	input wire pready, // rdy
	input wire pslverr, // err
	input wire [7:0] adc1_claim_i, // b claim
	input wire [7:0] adc2_claim_i, // a claim
	input wire [7:0] dac_claim_i, // b claim
	input wire [7:0] pa_oe_o, // a oe
	input wire [7:0] pa_pu_o, // a pu
	input wire [7:0] pa_analog_o, // a an
	input wire [7:0] pb_oe_o, // b oe
	input wire [7:0] pb_analog_o // b an
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_ready_high: assert property (pready) else $error("ready low");
	a_err_access: assert property (pslverr |-> penable && $past(psel) && !$past(penable))
		else $error("err outside access");
	a_pb_excl: assert property ((pb_oe_o & pb_analog_o) == 8'h00) else $error("pb oe");
	a_pa_excl: assert property ((pa_oe_o & pa_analog_o) == 8'h00) else $error("pa oe");
	a_pu_analog: assert property ((pa_pu_o & pa_analog_o) == 8'h00) else $error("pu");
	a_pb_claim: assert property ($past(rst_n_i) |->
		(pb_analog_o >> 1) == (($past(adc1_claim_i) | $past(dac_claim_i)) >> 1)) else $error("pb an");
	a_pa_claim: assert property ($past(rst_n_i) |->
		((pa_analog_o ^ $past(adc2_claim_i)) & 8'hEF) == 8'h00) else $error("pa an");
	a_reset_zero: assert property (disable iff (1'b0) !rst_n_i |=>
		pa_pu_o == 8'h00 && pb_oe_o == 8'h00) else $error("reset");
	c_err: cover property (pslverr);
	c_pb: cover property (pb_analog_o != 8'h00 && pb_oe_o != 8'h00);
	c_pu: cover property (pa_pu_o != 8'h00);
endmodule
bind gpab_top gpab_chk i_gpab_chk (.clk_i, .rst_n_i, .psel, .penable, .pready, .pslverr,
	.adc1_claim_i, .adc2_claim_i, .dac_claim_i, .pa_oe_o, .pa_pu_o, .pa_analog_o, .pb_oe_o,
	.pb_analog_o);

// >>> dv/gpab_top_tb.sv
// bench of the gpio top: random register and pin traffic
// assumes gpab_top, gpab_pins and the checker
`timescale 1ns/100ps
module gpab_top_tb;
	reg clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg se;
	reg [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
	reg [7:0] eo = 8'h00, ev = 8'h00, pbd = 8'h00, c1 = 8'h00, c2 = 8'h00, cd = 8'h00;
	reg [7:0] pu = 8'h00, dir = 8'h00, md = 8'h00, an, ex, adir = 8'h00, ad = 8'h00;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [7:0] pin, pa_out, pa_oe, pa_pu, pa_an, pb_oe, pb_out, pb_an;
	integer err_count = 0, samples_checked = 0, seed = 73731, cyc = 0, i;
	gpab_top i_gpab_top (.clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pa_pin_i(pin), .pb_pin_i(ev), .pb_data_i(pbd), .adc1_claim_i(c1),
		.adc2_claim_i(c2), .dac_claim_i(cd), .pfc_input_i(eo), .pa_out_o(pa_out), .pa_oe_o(pa_oe),
		.pa_pu_o(pa_pu), .pa_analog_o(pa_an), .pb_out_o(pb_out), .pb_oe_o(pb_oe),
		.pb_analog_o(pb_an));
	gpab_pins i_gpab_pins (.out_i(pa_out), .oe_i(pa_oe), .pu_i(pa_pu), .ext_oe_i(eo), .ext_i(ev),
		.pin_o(pin));
	initial forever #2.5 clk_i = ~clk_i;
	task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
	begin
		samples_checked = samples_checked + 1;
		if (s !== e)
		begin
			err_count = err_count + 1;
			$display("Error %0s exp %h seen %h", nm, e, s);
		end
	end
	endtask
	task apb(input w, input [23:0] a, input [7:0] d);
	begin
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {6'h00, a, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1)
			@(posedge clk_i);
		rd = prdata;
		se = pslverr;
		// psel left up so a following call is a true back-to-back setup
		penable <= 1'b0;
	end
	endtask
	task final_report;
	begin
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count = err_count + 1;
			final_report;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// pass 0 sees reset values, later passes the previous writes
		for (i = 0; i < 25; i = i + 1)
		begin
			repeat (6) @(posedge clk_i);
			an = {c2[7:5], md[3], c2[3:0]};
			apb(1'b0, 24'hFF0009, 8'h00);
			chk("mode", rd, md & 8'h0C);
			apb(1'b0, 24'hFF0019, 8'h00);
			chk("pullup", rd, pu);
			chk("pa_pu", pa_pu, pu & ~an & (~adir | eo));
			chk("pa_out", pa_out, ad);
			chk("pa_oe", pa_oe, adir & ~an);
			chk("pa_an", pa_an, an);
			apb(1'b0, 24'hFFFFFA, 8'h00);
			chk("pb_dir", rd, dir);
			chk("pb_oe", pb_oe, dir & ~{c1[7:1] | cd[7:1], md[2]});
			chk("pb_an", pb_an, {c1[7:1] | cd[7:1], md[2]});
			chk("pb_out", pb_out, pbd);
			apb(1'b0, 24'hFFFFF9, 8'h00);
			chk("pa_dir", rd, adir);
			apb(1'b0, 24'hFFFFE9, 8'h00);
			// input pins: outside value, else pull-up, else floating inverse
			ex = (eo & ev) | (~eo & ((pu & ~an) | ~ev));
			chk("pa_rd", rd, an | (adir & ad) | (~adir & ex));
			apb(1'b1, 24'hFF0000, 8'hFF);
			chk("unmapped", se, 1);
			pu = (i < 2) ? 8'hFF : $random(seed);
			dir = (i < 2) ? 8'hFF : $random(seed);
			md = (i == 1) ? 8'hFF : $random(seed);
			adir = (i == 0) ? 8'h0F : $random(seed);
			ad = $random(seed);
			ev <= $random(seed);
			eo <= $random(seed);
			c1 <= $random(seed) & 8'hFE;
			cd <= $random(seed) & 8'hFE;
			c2 <= (i < 2) ? 8'h00 : $random(seed);
			pbd <= $random(seed);
			apb(1'b1, 24'hFF0019, pu);
			apb(1'b1, 24'hFFFFFA, dir);
			apb(1'b1, 24'hFF0009, md);
			apb(1'b1, 24'hFFFFF9, adir);
			apb(1'b1, 24'hFFFFE9, ad);
			psel <= 1'b0;
			$display("test %0d done", i);
		end
		final_report;
	end
endmodule
